/* File: spdtf_data_tx.sv */
// port data transmit and pio interrupt state machine with apb registers
//
// Notes on behaviour
// - entering pio interrupt-set state sets this port's global pending bit
// - from interrupt-set go to interrupt generation if enabled, else aggregation
// - interrupt generation raises interrupt output, then goes to aggregation
// - interrupt stays raised until software clears it
// - transmit entry builds data frame for selected slot of current port
// - frame mux port field comes from that slot's command header
// - transmit entry fetches data for the slot and clears descriptor pending
// - nothing to send: state_a, switching idle or port idle; else transmit
// - transmit entry is entered only from port idle on a data request command
// - transmit sends until remaining count or 8KB has gone
// - frame ends on all bytes sent, table end or 8KB
// - descriptor pending set only after good status and descriptor interrupt bit
// - link error with switching enabled goes to non-fatal error
// - a dma terminate from the drive is ignored, frame continues
// - update optionally adds frame size to slot byte count
// - update subtracts frame size from remaining count
// - after update: descriptor interrupt, state_a, switching idle, port idle
// - descriptor interrupt sets done status, clears pending, propagates if enabled
`timescale 1ns/1ps
module spdtf_data_tx (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic MEM_VALID,
  input wire logic [31:0] MEM_DATA,
  input wire logic MEM_PRD_END,
  input wire logic MEM_PRD_IRQ,
  input wire logic MEM_TABLE_END,
  output logic MEM_READY,
  output logic TX_VALID,
  output logic [31:0] TX_DATA,
  output logic TX_LAST,
  output logic [3:0] TX_MUX,
  input wire logic TX_READY,
  input wire logic LINK_R_OK,
  input wire logic LINK_R_ERR,
  input wire logic LINK_SYNC_ESC,
  input wire logic LINK_FAIL,
  output logic INTR
);

  spdtf_pkg::spdtf_state_t state;
  spdtf_pkg::spdtf_state_t last_exit;
  logic [3:0] ctrl;
  logic [4:0] data_slot_index;
  logic [3:0] current_mux_port;
  logic pio_transfer_pending;
  logic [31:0] remaining_transfer_count;
  logic port_interrupt_pending_bit;
  logic descriptor_done_status;
  logic prd_interrupt_pending;
  logic prd_armed;
  logic fetch_on;
  logic [13:0] fis_bytes;
  logic [13:0] last_fis_bytes;
  logic apb_phase;
  logic [31:0] mem_rdata;
  spdtf_pkg::spdtf_mem_req_t mem_req;
  spdtf_pkg::spdtf_word_t out_word;
  spdtf_pkg::spdtf_word_t skid_word;
  spdtf_pkg::spdtf_word_t in_word;
  spdtf_pkg::spdtf_word_t next_out_word;
  spdtf_pkg::spdtf_word_t next_skid_word;
  logic skid_valid;
  logic next_out_valid;
  logic next_skid_valid;
  logic next_fetch_on;
  logic [13:0] next_bytes;
  logic push;
  logic pop;
  logic flush;
  logic global_interrupt_enable;
  logic switching_enable;
  logic descriptor_done_enable;
  logic bcnt_enable;
  logic apb_req;
  logic apb_done;
  logic apb_wr;
  logic hdr_sel;
  logic [1:0] cmd;
  logic clr_pend;
  logic clr_dds;
  logic [31:0] read_mux;

  assign global_interrupt_enable = ctrl[spdtf_pkg::CTRL_GIE_BIT];
  assign switching_enable = ctrl[spdtf_pkg::CTRL_FBS_BIT];
  assign descriptor_done_enable = ctrl[spdtf_pkg::CTRL_DDE_BIT];
  assign bcnt_enable = ctrl[spdtf_pkg::CTRL_BCNT_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a[11:8] == spdtf_pkg::HDR_PAGE) ||
                (a == spdtf_pkg::OFF_CTRL) || (a == spdtf_pkg::OFF_CMD) ||
                (a == spdtf_pkg::OFF_SETUP) || (a == spdtf_pkg::OFF_XFER) ||
                (a == spdtf_pkg::OFF_STATUS) ||
                (a == spdtf_pkg::OFF_INTSTAT) || (a == spdtf_pkg::OFF_FIS);
  endfunction

  // exit when the frame path is finished with this request
  function automatic spdtf_pkg::spdtf_state_t route_out(input logic pio,
                                                        input logic fbs);
    if (pio) begin
      route_out = spdtf_pkg::state_a;
    end else if (fbs) begin
      route_out = spdtf_pkg::switching_idle_state;
    end else begin
      route_out = spdtf_pkg::port_idle_state;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state for registers, two for the header window

  assign apb_req = PSEL && PENABLE && !PREADY;
  assign apb_done = PSEL && PENABLE && PREADY;
  assign apb_wr = apb_done && PWRITE;
  assign hdr_sel = PADDR[11:8] == spdtf_pkg::HDR_PAGE;
  assign cmd = (apb_wr && PADDR == spdtf_pkg::OFF_CMD) ? PWDATA[1:0] : 2'h0;
  assign clr_pend = apb_wr && PADDR == spdtf_pkg::OFF_INTSTAT &&
                    PWDATA[spdtf_pkg::INT_PEND_BIT];
  assign clr_dds = apb_wr && PADDR == spdtf_pkg::OFF_INTSTAT &&
                   PWDATA[spdtf_pkg::INT_DDS_BIT];

  always_comb begin
    read_mux = 32'h0000_0000;
    if (PADDR == spdtf_pkg::OFF_CTRL) begin
      read_mux[3:0] = ctrl;
    end else if (PADDR == spdtf_pkg::OFF_SETUP) begin
      read_mux[spdtf_pkg::SETUP_SLOT_LSB +: 5] = data_slot_index;
      read_mux[spdtf_pkg::SETUP_MUX_LSB +: 4] = current_mux_port;
      read_mux[spdtf_pkg::SETUP_PIO_BIT] = pio_transfer_pending;
    end else if (PADDR == spdtf_pkg::OFF_XFER) begin
      read_mux = remaining_transfer_count;
    end else if (PADDR == spdtf_pkg::OFF_STATUS) begin
      read_mux[spdtf_pkg::STAT_STATE_LSB +: 5] = state;
      read_mux[spdtf_pkg::STAT_EXIT_LSB +: 5] = last_exit;
      read_mux[spdtf_pkg::STAT_FETCH_BIT] = fetch_on;
      read_mux[spdtf_pkg::STAT_PRD_BIT] = prd_interrupt_pending;
      read_mux[spdtf_pkg::STAT_INTR_BIT] = INTR;
    end else if (PADDR == spdtf_pkg::OFF_INTSTAT) begin
      read_mux[spdtf_pkg::INT_PEND_BIT] = port_interrupt_pending_bit;
      read_mux[spdtf_pkg::INT_DDS_BIT] = descriptor_done_status;
    end else if (PADDR == spdtf_pkg::OFF_FIS) begin
      read_mux[13:0] = last_fis_bytes;
      read_mux[spdtf_pkg::FIS_MUX_LSB +: 4] = TX_MUX;
    end
  end

  // the header window is only opened while the machine is idle, so the
  // state machine always owns the single memory port during a request
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
      apb_phase <= 1'b0;
    end else begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      if (apb_req && hdr_sel) begin
        if (apb_phase) begin
          PREADY <= 1'b1;
          PRDATA <= PWRITE ? 32'h0000_0000 : mem_rdata;
          apb_phase <= 1'b0;
        end else if (state == spdtf_pkg::port_idle_state) begin
          apb_phase <= 1'b1;
        end
      end else if (apb_req) begin
        PREADY <= 1'b1;
        PSLVERR <= !is_mapped(PADDR);
        PRDATA <= PWRITE ? 32'h0000_0000 : read_mux;
      end
    end
  end

  // state machine reads have priority over the bus
  always_comb begin
    mem_req = '0;
    if (state == spdtf_pkg::transmit_entry_state) begin
      mem_req.re = 1'b1;
      mem_req.addr = {data_slot_index, spdtf_pkg::HDR_MUX_FIELD};
    end else if (state == spdtf_pkg::transmit_count_update_state) begin
      mem_req.re = bcnt_enable;
      mem_req.addr = {data_slot_index, spdtf_pkg::HDR_BCNT_FIELD};
    end else if (state == spdtf_pkg::count_rmw_state) begin
      mem_req.we = 1'b1;
      mem_req.addr = {data_slot_index, spdtf_pkg::HDR_BCNT_FIELD};
      mem_req.wdata = mem_rdata + {18'h00000, last_fis_bytes};
    end else begin
      mem_req.re = apb_req && hdr_sel && !apb_phase && !PWRITE &&
                   state == spdtf_pkg::port_idle_state;
      mem_req.we = apb_wr && hdr_sel;
      mem_req.addr = PADDR[7:2];
      mem_req.wdata = PWDATA;
    end
  end

  spdtf_hdr_mem u_hdr_mem (
    .CLK(CLK),
    .req(mem_req),
    .rdata(mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl <= spdtf_pkg::CTRL_RST;
      data_slot_index <= spdtf_pkg::SLOT_RST;
      current_mux_port <= spdtf_pkg::MUX_RST;
      pio_transfer_pending <= 1'b0;
    end else if (apb_wr && PADDR == spdtf_pkg::OFF_CTRL) begin
      ctrl <= PWDATA[3:0];
    end else if (apb_wr && PADDR == spdtf_pkg::OFF_SETUP) begin
      data_slot_index <= PWDATA[spdtf_pkg::SETUP_SLOT_LSB +: 5];
      current_mux_port <= PWDATA[spdtf_pkg::SETUP_MUX_LSB +: 4];
      pio_transfer_pending <= PWDATA[spdtf_pkg::SETUP_PIO_BIT];
    end
  end

  // hardware decrement wins over a software write in the same cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      remaining_transfer_count <= spdtf_pkg::XFER_RST;
    end else if (state == spdtf_pkg::transmit_count_update_state) begin
      if (remaining_transfer_count > {18'h00000, last_fis_bytes}) begin
        remaining_transfer_count <= remaining_transfer_count -
                                    {18'h00000, last_fis_bytes};
      end else begin
        remaining_transfer_count <= 32'h0000_0000;
      end
    end else if (apb_wr && PADDR == spdtf_pkg::OFF_XFER) begin
      remaining_transfer_count <= PWDATA;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt status: hardware set wins over a write-one clear

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      port_interrupt_pending_bit <= 1'b0;
      descriptor_done_status <= 1'b0;
      INTR <= 1'b0;
    end else begin
      if (state == spdtf_pkg::pio_port_intr_set_state ||
          state == spdtf_pkg::descriptor_set_is_state) begin
        port_interrupt_pending_bit <= 1'b1;
      end else if (clr_pend) begin
        port_interrupt_pending_bit <= 1'b0;
      end
      if (state == spdtf_pkg::descriptor_intr_state) begin
        descriptor_done_status <= 1'b1;
      end else if (clr_dds) begin
        descriptor_done_status <= 1'b0;
      end
      if (state == spdtf_pkg::pio_intr_generate_state ||
          (state == spdtf_pkg::descriptor_set_is_state &&
           global_interrupt_enable)) begin
        INTR <= 1'b1;
      end else if (clr_pend) begin
        INTR <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prd_interrupt_pending <= 1'b0;
    end else if (state == spdtf_pkg::transmit_entry_state ||
                 state == spdtf_pkg::descriptor_intr_state) begin
      prd_interrupt_pending <= 1'b0;
    end else if (state == spdtf_pkg::link_status_state && LINK_R_OK &&
                 !LINK_SYNC_ESC && prd_armed) begin
      prd_interrupt_pending <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // main state machine

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= spdtf_pkg::port_idle_state;
    end else begin
      case (state)
        spdtf_pkg::port_idle_state: begin
          if (cmd == spdtf_pkg::CMD_PIO_INTR) begin
            state <= spdtf_pkg::pio_port_intr_set_state;
          end else if (cmd == spdtf_pkg::CMD_DATA_REQ) begin
            state <= spdtf_pkg::transmit_entry_state;
          end
        end
        spdtf_pkg::pio_port_intr_set_state: begin
          if (global_interrupt_enable) begin
            state <= spdtf_pkg::pio_intr_generate_state;
          end else begin
            state <= spdtf_pkg::aggregation_state;
          end
        end
        spdtf_pkg::pio_intr_generate_state: begin
          state <= spdtf_pkg::aggregation_state;
        end
        spdtf_pkg::transmit_entry_state: begin
          if (remaining_transfer_count == 32'h0000_0000) begin
            state <= route_out(pio_transfer_pending,
                               switching_enable);
          end else begin
            state <= spdtf_pkg::hdr_wait_state;
          end
        end
        spdtf_pkg::hdr_wait_state: begin
          state <= spdtf_pkg::transmit_state;
        end
        spdtf_pkg::transmit_state: begin
          // a dma terminate from the drive has no input here on purpose
          if (LINK_SYNC_ESC) begin
            state <= spdtf_pkg::sync_escape_error_state;
          end else if (LINK_FAIL) begin
            state <= spdtf_pkg::fatal_error_state;
          end else if (pop && out_word.last) begin
            state <= spdtf_pkg::link_status_state;
          end
        end
        spdtf_pkg::link_status_state: begin
          if (LINK_SYNC_ESC) begin
            state <= spdtf_pkg::sync_escape_error_state;
          end else if (LINK_R_OK) begin
            state <= spdtf_pkg::transmit_count_update_state;
          end else if (LINK_R_ERR && switching_enable) begin
            state <= spdtf_pkg::nonfatal_error_state;
          end else if (LINK_R_ERR || LINK_FAIL) begin
            state <= spdtf_pkg::fatal_error_state;
          end
        end
        spdtf_pkg::transmit_count_update_state: begin
          if (bcnt_enable) begin
            state <= spdtf_pkg::count_rmw_state;
          end else if (prd_interrupt_pending) begin
            state <= spdtf_pkg::descriptor_intr_state;
          end else begin
            state <= route_out(pio_transfer_pending, switching_enable);
          end
        end
        spdtf_pkg::count_rmw_state: begin
          if (prd_interrupt_pending) begin
            state <= spdtf_pkg::descriptor_intr_state;
          end else begin
            state <= route_out(pio_transfer_pending, switching_enable);
          end
        end
        spdtf_pkg::descriptor_intr_state: begin
          if (descriptor_done_enable) begin
            state <= spdtf_pkg::descriptor_set_is_state;
          end else begin
            state <= route_out(pio_transfer_pending, switching_enable);
          end
        end
        spdtf_pkg::descriptor_set_is_state: begin
          state <= route_out(pio_transfer_pending, switching_enable);
        end
        default: begin
          // hand-off states: held for one cycle, then back to port idle
          state <= spdtf_pkg::port_idle_state;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      last_exit <= spdtf_pkg::port_idle_state;
    end else if (state == spdtf_pkg::aggregation_state ||
                 state == spdtf_pkg::state_a ||
                 state == spdtf_pkg::switching_idle_state ||
                 state == spdtf_pkg::nonfatal_error_state ||
                 state == spdtf_pkg::fatal_error_state ||
                 state == spdtf_pkg::sync_escape_error_state) begin
      last_exit <= state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // frame counting and header capture

  assign push = MEM_READY && MEM_VALID;
  assign pop = TX_VALID && TX_READY;
  assign flush = state != spdtf_pkg::transmit_state &&
                 state != spdtf_pkg::hdr_wait_state;
  assign next_bytes = fis_bytes + spdtf_pkg::WORD_BYTES;

  always_comb begin
    in_word.data = MEM_DATA;
    in_word.prd_end = MEM_PRD_END;
    in_word.prd_irq = MEM_PRD_IRQ;
    in_word.last = ({18'h00000, next_bytes} >= remaining_transfer_count) ||
                   (next_bytes == spdtf_pkg::FIS_MAX_BYTES) ||
                   MEM_TABLE_END;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fis_bytes <= 14'h0000;
      last_fis_bytes <= 14'h0000;
      prd_armed <= 1'b0;
      TX_MUX <= 4'h0;
    end else begin
      if (state == spdtf_pkg::transmit_entry_state) begin
        fis_bytes <= 14'h0000;
        prd_armed <= 1'b0;
      end else if (push && !flush) begin
        fis_bytes <= next_bytes;
      end
      if (state == spdtf_pkg::link_status_state) begin
        last_fis_bytes <= fis_bytes;
      end
      if (pop && out_word.prd_end && out_word.prd_irq) begin
        prd_armed <= 1'b1;
      end
      if (state == spdtf_pkg::hdr_wait_state) begin
        TX_MUX <= mem_rdata[3:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // two-entry skid buffer between fetch and link; outputs come from flops

  always_comb begin
    next_out_valid = TX_VALID;
    next_out_word = out_word;
    next_skid_valid = skid_valid;
    next_skid_word = skid_word;
    next_fetch_on = fetch_on;
    if (flush) begin
      next_out_valid = 1'b0;
      next_skid_valid = 1'b0;
      next_fetch_on = state == spdtf_pkg::transmit_entry_state &&
                      remaining_transfer_count != 32'h0000_0000;
    end else begin
      if (!TX_VALID || pop) begin
        if (skid_valid) begin
          next_out_word = skid_word;
          next_skid_valid = push;
          next_skid_word = in_word;
        end else begin
          next_out_valid = push;
          next_out_word = in_word;
        end
      end else if (push) begin
        next_skid_valid = 1'b1;
        next_skid_word = in_word;
      end
      if (push && in_word.last) begin
        next_fetch_on = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      TX_VALID <= 1'b0;
      out_word <= '0;
      skid_valid <= 1'b0;
      skid_word <= '0;
      fetch_on <= 1'b0;
      MEM_READY <= 1'b0;
    end else begin
      TX_VALID <= next_out_valid;
      out_word <= next_out_word;
      skid_valid <= next_skid_valid;
      skid_word <= next_skid_word;
      fetch_on <= next_fetch_on;
      // fetching stalls as soon as the skid entry is taken
      MEM_READY <= next_fetch_on && !next_skid_valid &&
                   state != spdtf_pkg::transmit_entry_state;
    end
  end

  assign TX_DATA = out_word.data;
  assign TX_LAST = out_word.last;

endmodule

/* File: spdtf_pkg.sv */
// shared constants and types for the port data transmit state machine
package spdtf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_CMD = 12'h004;
  localparam logic [11:0] OFF_SETUP = 12'h008;
  localparam logic [11:0] OFF_XFER = 12'h00C;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam logic [11:0] OFF_INTSTAT = 12'h014;
  localparam logic [11:0] OFF_FIS = 12'h018;
  // command header window: slot * 8 + field * 4
  localparam logic [3:0] HDR_PAGE = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTRL_GIE_BIT = 0;
  localparam int CTRL_FBS_BIT = 1;
  localparam int CTRL_DDE_BIT = 2;
  localparam int CTRL_BCNT_BIT = 3;
  localparam int SETUP_SLOT_LSB = 0;
  localparam int SETUP_MUX_LSB = 8;
  localparam int SETUP_PIO_BIT = 16;
  localparam int INT_PEND_BIT = 0;
  localparam int INT_DDS_BIT = 1;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_EXIT_LSB = 8;
  localparam int STAT_FETCH_BIT = 16;
  localparam int STAT_PRD_BIT = 17;
  localparam int STAT_INTR_BIT = 18;
  localparam int FIS_MUX_LSB = 16;
  localparam logic HDR_MUX_FIELD = 1'b0;
  localparam logic HDR_BCNT_FIELD = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // reset values, command codes, sizes
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [4:0] SLOT_RST = 5'h00;
  localparam logic [3:0] MUX_RST = 4'h0;
  localparam logic [31:0] XFER_RST = 32'h0000_0000;
  localparam logic [1:0] CMD_PIO_INTR = 2'h1;
  localparam logic [1:0] CMD_DATA_REQ = 2'h2;
  localparam logic [13:0] FIS_MAX_BYTES = 14'h2000;
  localparam logic [13:0] WORD_BYTES = 14'h0004;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [4:0] {
    port_idle_state,
    pio_port_intr_set_state,
    pio_intr_generate_state,
    aggregation_state,
    transmit_entry_state,
    hdr_wait_state,
    transmit_state,
    link_status_state,
    transmit_count_update_state,
    count_rmw_state,
    descriptor_intr_state,
    descriptor_set_is_state,
    state_a,
    switching_idle_state,
    nonfatal_error_state,
    fatal_error_state,
    sync_escape_error_state
  } spdtf_state_t;

  typedef struct packed {
    logic [31:0] data;
    logic last;
    logic prd_end;
    logic prd_irq;
  } spdtf_word_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [5:0] addr;
    logic [31:0] wdata;
  } spdtf_mem_req_t;

endpackage

/* File: spdtf_hdr_mem.sv */
// command header store: mux port field and descriptor byte count per slot
`timescale 1ns/1ps
module spdtf_hdr_mem (
  input wire logic CLK,
  input wire spdtf_pkg::spdtf_mem_req_t req,
  output logic [31:0] rdata
);
  logic [31:0] mem [0:63];

  // no reset on the array; read data is registered
  always_ff @(posedge CLK) begin
    if (req.we) begin
      mem[req.addr] <= req.wdata;
    end
    if (req.re) begin
      rdata <= mem[req.addr];
    end
  end
endmodule

/* File: spdtf_link_model.sv */
// drive-side link model: random stalls, one status pulse per frame
`timescale 1ns/1ps
module spdtf_link_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic [1:0] mode,
  output logic tx_ready,
  output logic [3:0] stat
);
  int seed = 87;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
      stat <= 4'h0;
    end else begin
      tx_ready <= ($random(seed) & 3) != 0;
      // status only after the last word; mode picks ok or one fault
      stat <= (tx_valid && tx_ready && tx_last) ? 4'h8 >> mode : 4'h0;
    end
  end
endmodule

/* File: spdtf_data_tx_chk.sv */
// port-level checks for the data transmit block
`timescale 1ns/1ps
module spdtf_data_tx_chk (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire logic [31:0] TX_DATA,
  input wire logic MEM_VALID,
  input wire logic MEM_READY,
  input wire logic INTR
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_acc;
    PSEL && !PENABLE ##1 PSEL && PENABLE;
  endsequence
  a_rdy_bound: assert property (s_acc |-> ##[0:300] PREADY)
    else $error("no apb answer");
  a_rdy_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_rdy_cause: assert property (PREADY |-> $past(PSEL && PENABLE))
    else $error("ready without access");
  a_tx_hold: assert property (TX_VALID && !TX_READY |=>
    TX_VALID && $stable(TX_DATA)) else $error("stalled word lost");
  a_tx_source: assert property ($rose(TX_VALID) |->
    $past(MEM_VALID && MEM_READY)) else $error("word from nowhere");
  a_intr_hold: assert property ($fell(INTR) |->
    $past(PREADY && PWRITE)) else $error("interrupt dropped");
  a_reset_quiet: assert property ($rose(RST_N) |->
    !INTR && !TX_VALID && !PREADY) else $error("busy after reset");
endmodule
bind spdtf_data_tx spdtf_data_tx_chk u_spdtf_data_tx_chk (.*);

/* File: spdtf_data_tx_tb.sv */
// self-checking bench for the data transmit block
`timescale 1ns/1ps
module spdtf_data_tx_tb;
  logic CLK=0, RST_N=0, PSEL=0, PENABLE=0, PWRITE=0, MEM_VALID=0, serr;
  logic MEM_PRD_END=0, MEM_PRD_IRQ=0, MEM_TABLE_END=0;
  logic [11:0] PADDR=12'h000;
  logic [31:0] PWDATA=32'h0, MEM_DATA=32'h0, rd;
  wire [31:0] PRDATA, TX_DATA;
  wire [3:0] TX_MUX;
  wire PREADY, PSLVERR, MEM_READY, TX_VALID, TX_LAST, TX_READY, INTR;
  wire LINK_R_OK, LINK_R_ERR, LINK_SYNC_ESC, LINK_FAIL;
  logic [1:0] mode=2'h0;
  int error_cnt=0, n_checks=0, seed=87;
  logic [31:0] mq[$];
  logic [32:0] eq[$];
  logic [4:0] ex[4]='{5'h00, 5'h0E, 5'h10, 5'h0F};
  spdtf_data_tx u_spdtf_data_tx (.*);
  spdtf_link_model u_spdtf_link_model (.clk(CLK), .rst_n(RST_N),
    .tx_valid(TX_VALID), .tx_last(TX_LAST), .mode(mode),
    .tx_ready(TX_READY),
    .stat({LINK_R_OK, LINK_R_ERR, LINK_SYNC_ESC, LINK_FAIL}));
  always #2.5 CLK = ~CLK;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string s, logic [32:0] seen, logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int t=0;
    @(posedge CLK);
    PSEL <= 1'b1; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (!PREADY && ++t < 400);
    if (t == 400) error_cnt++;
    rd = PRDATA; serr = PSLVERR; PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask
  task automatic wait_idle;
    int t=0;
    do apb(1'b0, 12'h010, 32'h0); while (rd[4:0] != 5'h00 && ++t < 3000);
    if (t == 3000) error_cnt++;
  endtask
  // reference frame: a word is last at the byte total or each 8KB boundary
  task automatic frame(int n, logic ck);
    logic [31:0] d;
    for (int i = 1; i <= n / 4; i++) begin
      d = $random(seed);
      mq.push_back(d);
      if (ck) eq.push_back({i * 4 == n || i % 2048 == 0, d});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge CLK) if (!MEM_VALID || MEM_READY) begin
    MEM_VALID <= mq.size() != 0;
    MEM_PRD_END <= mq.size() == 1;
    MEM_PRD_IRQ <= mq.size() == 1;
    MEM_TABLE_END <= mq.size() == 1;
    if (mq.size() != 0) MEM_DATA <= mq.pop_front();
  end
  always @(posedge CLK) if (TX_VALID && TX_READY && eq.size() != 0) begin
    chk("tx word", {TX_LAST, TX_DATA}, eq.pop_front());
    chk("tx mux port", 33'(TX_MUX), 33'h9);
  end
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl reset", 33'(rd), 33'h0);
    apb(1'b0, 12'h0F0, 32'h0);
    chk("unmapped", {serr, rd}, 33'h1_0000_0000);
    apb(1'b1, 12'h004, 32'h1);
    wait_idle();
    apb(1'b0, 12'h014, 32'h0);
    chk("pending no intr", {INTR, rd}, 33'h1);
    apb(1'b1, 12'h014, 32'h1);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h004, 32'h1);
    wait_idle();
    chk("intr held", 33'(INTR), 33'h1);
    apb(1'b1, 12'h014, 32'h1);
    @(posedge CLK);
    chk("intr cleared", 33'(INTR), 33'h0);
    $display("test pio interrupt done");
    // 8200 bytes need two frames, the first cut at 8KB
    apb(1'b1, 12'h000, 32'hD);
    apb(1'b1, 12'h008, 32'h0503);
    apb(1'b1, 12'h118, 32'h9);
    apb(1'b1, 12'h11C, 32'h0);
    apb(1'b1, 12'h00C, 32'h2008);
    frame(8200, 1'b1);
    for (int f = 0; f < 2; f++) begin
      apb(1'b1, 12'h004, 32'h2);
      wait_idle();
    end
    chk("words left", 33'(eq.size()), 33'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk("remaining", 33'(rd), 33'h0);
    apb(1'b0, 12'h018, 32'h0);
    chk("frame info", 33'(rd), 33'h9_0008);
    apb(1'b0, 12'h11C, 32'h0);
    chk("byte count", 33'(rd), 33'h2008);
    apb(1'b0, 12'h014, 32'h0);
    chk("desc done", {INTR, rd}, 33'h1_0000_0003);
    $display("test transmit done");
    apb(1'b1, 12'h008, 32'h1_0503);
    apb(1'b1, 12'h004, 32'h2);
    wait_idle();
    chk("empty exit", 33'(rd[12:8]), 33'hC);
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b1, 12'h008, 32'h0503);
    for (int m = 1; m < 4; m++) begin
      mode <= 2'(m);
      // count larger than the data, so only the table end closes the frame
      apb(1'b1, 12'h00C, 32'h10);
      frame(8, 1'b0);
      apb(1'b1, 12'h004, 32'h2);
      wait_idle();
      chk("fault exit", 33'(rd[12:8]), 33'(ex[m]));
      mq.delete();
    end
    $display("test link faults done");
    end_of_test();
  end
endmodule
